// [xbus_glue_pkg.sv]
// Constants and carrier types for the X-bus decode and CPU reset glue
package xbus_glue_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_MHZ           = 125;
   localparam int unsigned SOFT_RESET_CLKS   = 4;
   localparam int unsigned HARD_RESET_US     = 1000;
   localparam int unsigned HARD_RESET_CLKS   = HARD_RESET_US * CLK_MHZ;
   localparam int unsigned STRAP_DELAY_CLKS  = 2;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int unsigned P92_HOT_RESET_BIT = 0;
   localparam int unsigned P92_STRAP_BIT     = 2;
   localparam int unsigned CFG4E_KBD_RST_BIT = 1;
   localparam int unsigned CFG4E_COPROC_BIT  = 4;
   localparam logic [11:0] HIGH_PORT_BASE    = 12'h0800;
   localparam logic [11:0] HIGH_PORT_MASK    = 12'h0F00;

   // ----------------------------------------
   // X-bus device codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      XCODE_IDLE     = 2'h0,
      XCODE_RTC_ADDR = 2'h1,
      XCODE_RTC_DATA = 2'h2,
      XCODE_ROM_KBD  = 2'h3
   } xsel_code_t;

   // Decoded access from the bridge core
   typedef struct packed {
      logic        rtc_addr;
      logic        rtc_data;
      logic        rom;
      logic        kbd;
      logic        io_cycle;
      logic [15:0] io_addr;
      logic        read;
   } xbus_access_t;

   // Reset trigger events from the configuration logic
   typedef struct packed {
      logic hot_reset;
      logic shutdown;
      logic kbd_reset;
      logic reset_drive;
   } reset_events_t;

endpackage

// [xbus_decode_cpu_reset_glue.sv]
// X-bus decode and steering, strap capture and CPU sideband reset glue
//
// Overview of operation
// - Read strobe low steers X-bus data to ISA
// - RISC mode: read pin strap shown port 92 bit2
// - Buffer enable asserted on any X-bus decode outside test mode
// - Buffer enable strap low selects test mode
// - RISC mode: low select is ROM select
// - RISC mode: high select for 800h-8FFh I/O
// - x86 mode: selects carry encoded device code
// - Code: idle, RTC addr, RTC data, ROM/keyboard
// - Mode strap sampled after reset picks pin functions
// - x86: soft reset four clocks per event
// - RISC: hard reset one millisecond per event
// - x86: shared pin is ignore-numeric-error
// - Shared input: interrupt 13 unless 4Eh bit4
// - RISC: hard and ISA resets derived from power-good input
// - CPU interrupt driven from interrupt controller
// - RISC: ISA reset one millisecond per trigger
`timescale 1ns/100ps
module xbus_decode_cpu_reset_glue #(
   parameter int unsigned HARD_RESET_CLKS = xbus_glue_pkg::HARD_RESET_CLKS,
   parameter int unsigned SOFT_RESET_CLKS = xbus_glue_pkg::SOFT_RESET_CLKS
) (
   input  wire logic                         clk_i,
   input  wire logic                         reset_n_i,
   input  wire logic                         power_ok_in_i,
   input  wire logic                         risc_mode_strap_i,
   input  wire logic                         xbus_read_n_i,
   input  wire logic                         xbus_buffer_enable_n_i,
   input  wire xbus_glue_pkg::xbus_access_t  access_i,
   input  wire xbus_glue_pkg::reset_events_t events_i,
   input  wire logic                         coproc_select_i,
   input  wire logic                         pic_int_i,
   input  wire logic                         fp_ignore_i,
   input  wire logic                         shared_irq_pin_i,
   input  wire logic [7:0]                   xbus_data_i,
   output logic [7:0]                        isa_system_data_o,
   output logic                              isa_data_steer_o,
   output logic                              xbus_read_n_o,
   output logic                              xbus_read_n_oe_o,
   output logic                              xbus_buffer_enable_n_o,
   output logic                              xbus_buffer_enable_n_oe_o,
   output logic                              xsel_low_o,
   output logic                              xsel_high_o,
   output logic                              strap_lock_sense_o,
   output logic                              risc_mode_o,
   output logic                              test_mode_o,
   output logic                              cpu_soft_reset_o,
   output logic                              cpu_hard_reset_n_o,
   output logic                              ignore_fp_error_n_o,
   output logic                              legacy_bus_reset_o,
   output logic                              irq_line_thirteen_o,
   output logic                              coproc_error_n_o,
   output logic                              cpu_int_o
);

   localparam int unsigned HW = $clog2(HARD_RESET_CLKS + 1);
   localparam int unsigned SW = $clog2(SOFT_RESET_CLKS + 1);

   // Zero-length pulses would leave the counters stuck idle
   if (HARD_RESET_CLKS < 1 || SOFT_RESET_CLKS < 1) begin : g_bad_len
      $error("Reset pulse lengths must be at least one cycle");
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [4:0] sync_a;
   logic [4:0] sync_b;
   wire  [4:0] pins = {power_ok_in_i, risc_mode_strap_i, xbus_read_n_i,
                       xbus_buffer_enable_n_i, shared_irq_pin_i};

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync_a <= 5'h00;
         sync_b <= 5'h00;
      end else begin
         sync_a <= pins;
         sync_b <= sync_a;
      end
   end

   wire pwr_ok   = sync_b[4];
   wire mode_pin = sync_b[3];
   wire rd_pin   = sync_b[2];
   wire oe_pin   = sync_b[1];
   wire irq_pin  = sync_b[0];

   // ----------------------------------------
   // Strap capture after reset release
   // ----------------------------------------
   logic [1:0] strap_wait;
   logic       straps_done;
   logic       risc_mode;
   logic       test_mode;
   logic       rd_strap;

   // Pins float as inputs until straps are latched, so nothing drives them early
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         strap_wait  <= 2'h0;
         straps_done <= 1'b0;
         risc_mode   <= 1'b0;
         test_mode   <= 1'b0;
         rd_strap    <= 1'b0;
      end else if (!straps_done) begin
         strap_wait <= strap_wait + 2'h1;
         if (strap_wait == 2'(xbus_glue_pkg::STRAP_DELAY_CLKS)) begin
            straps_done <= 1'b1;
            risc_mode   <= mode_pin;
            test_mode   <= !oe_pin;
            rd_strap    <= rd_pin;
         end
      end
   end

   assign risc_mode_o        = risc_mode;
   assign test_mode_o        = test_mode;
   assign strap_lock_sense_o = rd_strap;  // Port 92 bit 2 view

   // ----------------------------------------
   // X-bus decode and steering
   // ----------------------------------------
   wire rom_or_kbd = access_i.rom | access_i.kbd;
   wire high_port  = access_i.io_cycle &
                     ((access_i.io_addr[11:0] & xbus_glue_pkg::HIGH_PORT_MASK)
                      == xbus_glue_pkg::HIGH_PORT_BASE) &
                     (access_i.io_addr[15:12] == 4'h0);
   wire any_dev    = access_i.rtc_addr | access_i.rtc_data | rom_or_kbd |
                     (risc_mode & high_port);

   xbus_glue_pkg::xsel_code_t code;
   assign code = rom_or_kbd        ? xbus_glue_pkg::XCODE_ROM_KBD  :
                 access_i.rtc_data ? xbus_glue_pkg::XCODE_RTC_DATA :
                 access_i.rtc_addr ? xbus_glue_pkg::XCODE_RTC_ADDR :
                                     xbus_glue_pkg::XCODE_IDLE;

   wire live       = straps_done & !test_mode;
   wire next_low   = risc_mode ? access_i.rom : code[0];
   wire next_high  = risc_mode ? high_port    : code[1];
   wire next_rd_n  = !(any_dev & access_i.read);
   wire next_oe_n  = !any_dev;

   logic       sel_low;
   logic       sel_high;
   logic       rd_n;
   logic       oe_n;
   logic [7:0] bus_data;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sel_low  <= 1'b0;
         sel_high <= 1'b0;
         rd_n     <= 1'b1;
         oe_n     <= 1'b1;
         bus_data <= 8'h00;
      end else begin
         sel_low  <= live & next_low;
         sel_high <= live & next_high;
         rd_n     <= !live | next_rd_n;
         oe_n     <= !live | next_oe_n;
         bus_data <= xbus_data_i;
      end
   end

   assign xsel_low_o                = sel_low;
   assign xsel_high_o               = sel_high;
   assign xbus_read_n_o             = rd_n;
   assign xbus_read_n_oe_o          = straps_done;
   assign xbus_buffer_enable_n_o    = oe_n;
   assign xbus_buffer_enable_n_oe_o = straps_done;
   assign isa_data_steer_o          = !rd_n;
   assign isa_system_data_o         = bus_data;

   // ----------------------------------------
   // CPU reset pulses
   // ----------------------------------------
   logic pwr_ok_d;
   wire  pwr_rise  = pwr_ok & !pwr_ok_d;
   wire  cpu_event = events_i.hot_reset | events_i.shutdown | events_i.kbd_reset;
   wire  hard_trig = risc_mode & (pwr_rise | cpu_event);
   wire  isa_trig  = risc_mode & (pwr_rise | events_i.hot_reset |
                                  events_i.reset_drive);
   wire  soft_trig = straps_done & !risc_mode & cpu_event;

   logic [HW-1:0] hard_cnt;
   logic [HW-1:0] isa_cnt;
   logic [SW-1:0] soft_cnt;

   // Any new trigger reloads the count, stretching an active pulse
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwr_ok_d <= 1'b0;
         hard_cnt <= '0;
         isa_cnt  <= '0;
         soft_cnt <= '0;
      end else begin
         pwr_ok_d <= pwr_ok;
         if (hard_trig) begin
            hard_cnt <= HW'(HARD_RESET_CLKS);
         end else if (hard_cnt != '0) begin
            hard_cnt <= hard_cnt - HW'(1);
         end
         if (isa_trig) begin
            isa_cnt <= HW'(HARD_RESET_CLKS);
         end else if (isa_cnt != '0) begin
            isa_cnt <= isa_cnt - HW'(1);
         end
         if (soft_trig) begin
            soft_cnt <= SW'(SOFT_RESET_CLKS);
         end else if (soft_cnt != '0) begin
            soft_cnt <= soft_cnt - SW'(1);
         end
      end
   end

   assign cpu_soft_reset_o = soft_cnt != '0;
   // Shared pin: hard reset in RISC mode, ignore-error in x86 mode
   assign cpu_hard_reset_n_o  = !(risc_mode & (hard_cnt != '0));
   assign ignore_fp_error_n_o = risc_mode ? 1'b1 : !fp_ignore_i;
   assign legacy_bus_reset_o  = isa_cnt != '0;

   // ----------------------------------------
   // Interrupt and coprocessor error routing
   // ----------------------------------------
   assign irq_line_thirteen_o = !coproc_select_i & irq_pin;
   assign coproc_error_n_o    = coproc_select_i ? irq_pin : 1'b1;
   assign cpu_int_o           = pic_int_i;

endmodule

// [xbus_glue_asserts.sv]
// Port checker for the X-bus decode and CPU reset glue
`timescale 1ns/100ps
module xbus_glue_asserts #(
   parameter int unsigned HARD_RESET_CLKS = xbus_glue_pkg::HARD_RESET_CLKS
) (
   input wire logic                         clk_i,
   input wire logic                         reset_n_i,
   input wire xbus_glue_pkg::xbus_access_t  access_i,
   input wire xbus_glue_pkg::reset_events_t events_i,
   input wire logic [7:0]                   xbus_data_i,
   input wire logic [7:0]                   isa_system_data_o,
   input wire logic                         xbus_buffer_enable_n_o,
   input wire logic                         xsel_low_o,
   input wire logic                         xsel_high_o,
   input wire logic                         risc_mode_o,
   input wire logic                         test_mode_o,
   input wire logic                         cpu_soft_reset_o,
   input wire logic                         cpu_hard_reset_n_o,
   input wire logic                         fp_ignore_i,
   input wire logic                         ignore_fp_error_n_o,
   input wire logic                         pic_int_i,
   input wire logic                         cpu_int_o
);
   logic [2:0]  cnt;
   logic [31:0] q;
   wire         ok   = cnt >= 3'h3 && !test_mode_o;
   wire         dev  = access_i.rom | access_i.kbd | access_i.rtc_data | access_i.rtc_addr;
   wire [1:0]   code = (access_i.rom | access_i.kbd) ? 2'h3 :
                       {access_i.rtc_data, access_i.rtc_addr & !access_i.rtc_data};
   wire         hp   = access_i.io_cycle && access_i.io_addr[15:8] == 8'h08;
   wire         trig = events_i.hot_reset | events_i.shutdown | events_i.kbd_reset;
   // Runs one past the end so the release check fires for a single cycle only
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt <= 3'h0;
         q <= 32'h0000_0000;
      end else begin
         if (cnt != 3'h7) cnt <= cnt + 3'h1;
         if (ok && risc_mode_o && trig) q <= 32'h0000_0001;
         else if (q != 32'h0000_0000 && q <= HARD_RESET_CLKS + 1) q <= q + 32'h0000_0001;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_soft_go;
      ok && !risc_mode_o && trig;
   endsequence
   a_data_path: assert property (cnt >= 3'h3 |->
      isa_system_data_o == $past(xbus_data_i)) else $error("isa data lost");
   a_buffer_on: assert property (ok && dev |=> !xbus_buffer_enable_n_o)
      else $error("buffer enable missing");
   a_test_idle: assert property (test_mode_o |-> !xsel_low_o && !xsel_high_o)
      else $error("select in test mode");
   a_risc_sel: assert property (ok && risc_mode_o |=>
      xsel_low_o == $past(access_i.rom) && xsel_high_o == $past(hp)) else $error("risc select");
   a_x86_code: assert property (ok && !risc_mode_o |=>
      {xsel_high_o, xsel_low_o} == $past(code)) else $error("device code wrong");
   a_soft_len: assert property (s_soft_go |=> cpu_soft_reset_o [*4])
      else $error("soft reset short");
   a_soft_end: assert property (s_soft_go ##1 !trig [*4] |=> !cpu_soft_reset_o)
      else $error("soft reset long");
   a_hard_low: assert property (q != 0 && q <= HARD_RESET_CLKS |->
      !cpu_hard_reset_n_o) else $error("hard reset short");
   a_hard_end: assert property (q == HARD_RESET_CLKS + 1 |-> cpu_hard_reset_n_o)
      else $error("hard reset long");
   a_fp_route: assert property (ignore_fp_error_n_o == (risc_mode_o | !fp_ignore_i))
      else $error("ignore error pin wrong");
   a_int_route: assert property (cpu_int_o == pic_int_i)
      else $error("cpu interrupt wrong");
endmodule
bind xbus_decode_cpu_reset_glue xbus_glue_asserts #(.HARD_RESET_CLKS(HARD_RESET_CLKS)) u_chk (.*);

// [xbus_glue_partner.sv]
// External X-bus decoder and device model
`timescale 1ns/100ps
module xbus_glue_partner (
   input  wire logic       clk_i,
   input  wire logic       xbus_read_n_i,
   input  wire logic       xsel_low_i,
   input  wire logic       xsel_high_i,
   output logic [7:0]      xbus_data_o
);
   logic [7:0] last = 8'h00;
   // Selected device answers with its code; released bus flips every cycle
   assign xbus_data_o = !xbus_read_n_i ? {4'hA, 2'h0, xsel_high_i, xsel_low_i} : ~last;
   always_ff @(posedge clk_i) last <= xbus_data_o;
endmodule

// [xbus_decode_cpu_reset_glue_tb.sv]
// Testbench for the X-bus decode and CPU reset glue
`timescale 1ns/100ps
module xbus_decode_cpu_reset_glue_tb;
   localparam int unsigned HR = 20;
   logic clk_i, reset_n_i, power_ok_in_i, risc_mode_strap_i, coproc_select_i;
   logic pic_int_i, fp_ignore_i, shared_irq_pin_i, rs, os;
   xbus_glue_pkg::xbus_access_t  access_i, a;
   xbus_glue_pkg::reset_events_t events_i;
   logic [7:0] xbus_data_i, isa_system_data_o;
   logic isa_data_steer_o, xbus_read_n_o, xbus_read_n_oe_o, xbus_buffer_enable_n_o;
   logic xbus_buffer_enable_n_oe_o, xsel_low_o, xsel_high_o, strap_lock_sense_o;
   logic risc_mode_o, test_mode_o, cpu_soft_reset_o, cpu_hard_reset_n_o, cpu_int_o;
   logic ignore_fp_error_n_o, legacy_bus_reset_o, irq_line_thirteen_o, coproc_error_n_o;
   int failures = 0, n_tests = 0;
   // Pins are pulled to the strap level while the block is not driving
   wire xbus_read_n_i = xbus_read_n_oe_o ? xbus_read_n_o : rs;
   wire xbus_buffer_enable_n_i = xbus_buffer_enable_n_oe_o ? xbus_buffer_enable_n_o : os;
   xbus_decode_cpu_reset_glue #(.HARD_RESET_CLKS(HR)) u_xbus_decode_cpu_reset_glue (.*);
   xbus_glue_partner u_xbus_glue_partner (.clk_i(clk_i), .xbus_read_n_i(xbus_read_n_i),
      .xsel_low_i(xsel_low_o), .xsel_high_i(xsel_high_o), .xbus_data_o(xbus_data_i));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("tests=%0d failures=%0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic boot(input logic r, input logic s, input logic o);
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      risc_mode_strap_i <= r;
      rs <= s;
      os <= o;
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (40) @(posedge clk_i);
      #1;
   endtask
   task automatic acc(input xbus_glue_pkg::xbus_access_t x, input logic [1:0] xs, input logic bn);
      @(posedge clk_i);
      access_i <= x;
      @(posedge clk_i);
      access_i <= '0;
      #1;
      chk({xsel_high_o, xsel_low_o}, xs);
      chk(xbus_buffer_enable_n_o, bn);
      chk(xbus_read_n_o, !(x.read & !bn));
      chk(isa_data_steer_o, x.read & !bn);
      @(posedge clk_i);
      #1;
      if (x.read & !bn) chk(isa_system_data_o, {4'hA, 2'h0, xs});
   endtask
   task automatic fire(input logic [3:0] ev, input int gap, input logic pg, input int es,
                       input int eh, input int ei);
      int ns, nh, ni;
      ns = 0;
      nh = 0;
      ni = 0;
      @(posedge clk_i);
      power_ok_in_i <= !pg;
      repeat (4) @(posedge clk_i);
      power_ok_in_i <= 1'b1;
      events_i <= ev;
      for (int i = 0; i < 60; i++) begin
         @(posedge clk_i);
         events_i <= (gap != 0 && i == gap) ? ev : 4'h0;
         #1;
         ns += (cpu_soft_reset_o === 1'b1);
         nh += (cpu_hard_reset_n_o === 1'b0);
         ni += (legacy_bus_reset_o === 1'b1);
      end
      chk(ns, es);
      chk(nh, eh);
      chk(ni, ei);
   endtask
   task automatic mode_run(input logic r);
      for (int i = 0; i < 4; i++)
         fire(4'h8 >> i, 0, 0, (!r && i < 3) ? 4 : 0, (r && i < 3) ? HR : 0,
              (r && i % 3 == 0) ? HR : 0);
      for (int j = 0; j < 4; j++) begin
         @(posedge clk_i);
         coproc_select_i <= j[1];
         shared_irq_pin_i <= j[0];
         pic_int_i <= j[0];
         fp_ignore_i <= j[0];
         repeat (3) @(posedge clk_i);
         #1;
         chk(j[1] ? coproc_error_n_o : irq_line_thirteen_o, j[0]);
         chk(j[1] ? irq_line_thirteen_o : coproc_error_n_o, !j[1]);
         chk(cpu_int_o, j[0]);
         chk(ignore_fp_error_n_o, r | !j[0]);
      end
   endtask
   initial begin
      #100000;
      failures++;
      summarize();
   end
   initial begin
      {reset_n_i, risc_mode_strap_i, rs, coproc_select_i, pic_int_i, fp_ignore_i} = '0;
      {power_ok_in_i, os, shared_irq_pin_i} = 3'h6;
      access_i = '0;
      events_i = '0;
      boot(1'b0, 1'b0, 1'b1);
      chk(risc_mode_o, 1'b0);
      chk(test_mode_o, 1'b0);
      chk({xbus_read_n_oe_o, xbus_buffer_enable_n_oe_o}, 2'h3);
      for (int i = 0; i < 4; i++) begin
         a = '0;
         a[21 - i] = 1'b1;
         a.read = (i != 0);
         acc(a, (i > 1) ? 2'h3 : 2'(i + 1), 1'b0);
      end
      acc('0, 2'h0, 1'b1);
      mode_run(1'b0);
      boot(1'b1, 1'b1, 1'b1);
      chk(risc_mode_o, 1'b1);
      chk(strap_lock_sense_o, 1'b1);
      a = '0;
      a.rom = 1'b1;
      a.read = 1'b1;
      acc(a, 2'h1, 1'b0);
      a = '0;
      a.io_cycle = 1'b1;
      for (int k = 0; k < 4; k++) begin
         a.io_addr = (k == 0) ? 16'h0800 : (k == 1) ? 16'h08FF : (k == 2) ? 16'h0900 : 16'h07FF;
         acc(a, (k < 2) ? 2'h2 : 2'h0, k > 1);
      end
      mode_run(1'b1);
      fire(4'h8, 9, 1'b0, 0, HR + 10, HR + 10);
      fire(4'h0, 0, 1'b1, 0, HR, HR);
      boot(1'b0, 1'b0, 1'b0);
      chk(test_mode_o, 1'b1);
      a = '0;
      a.rom = 1'b1;
      a.read = 1'b1;
      acc(a, 2'h0, 1'b1);
      summarize();
   end
endmodule
